/* logic/touchpad_params.svh */
// Constants for the touchpad secondary-function controller: register map,
// field positions, reset values and timing figures.
// Assumes a single 200 MHz system clock and a synchronous active-low reset.
// Contract
// (R1) Ignition on and DRIVE: switch to outermost columns after five seconds.
// (R2) Column-select keys change the active column manually at any time.
// (R3) Dual-function keys act on the function of the highlighted column.
// (R4) Wild-card keys are remapped according to the active column.
// (R5) Always-active keys ignore column; aux two/three may be ignition-interlocked.
// (R6) Status window shows battery voltage, software revision or programming info.
// (R7) Column 1 lights key steps parking, headlights, then all off.
// (R8) Headlights on and column 1: left wild-card toggles low/high beam.
// (R9) Last beam state is kept when ignition or lights turn off.
// (R10) Backlight lit while parking lights are active.
// (R11) Wake from sleep lights the backlight for 90 seconds.
// (R12) Ignition turning off lights the backlight for 90 seconds.
// (R13) Headlight option: manual, on with wipers, or on with ignition.
// (R14) Headlights are never switched off automatically, only by a key.
// (R15) Column 1 wiper key steps off, intermittent, low, high, off.
// (R16) Intermittent mode pauses a fixed five seconds between wipes.
// (R17) Holding the wiper key 2-3 seconds starts the washer at any speed.
// (R18) Wash hold from off: on release wash and wipe briefly, then off; the code stops the washer at release and only wipes.
// (R19) Functions are driven by keys or by commands over the port.
// (R20) Keys are debounced and classified as short presses or timed holds.
// (R21) Reset starts lights, wipers and timers off, backlight timer cleared.
`ifndef TOUCHPAD_PARAMS_SVH
`define TOUCHPAD_PARAMS_SVH

// Clock and time figures
`define CLK_HZ 200000000
`define DEBOUNCE_MS 10
`define AUTO_SHIFT_SEC 5
`define BACKLIGHT_SEC 90
`define INT_PAUSE_SEC 5
`define WIPE_SEC 1
`define WASH_HOLD_SEC 2
`define WASH_BRIEF_SEC 3

// Key bit positions
`define KEY_LIGHTS 0
`define KEY_WIPER 1
`define KEY_WILD_LEFT 2
`define KEY_WILD_RIGHT 3
`define KEY_COL_LEFT 4
`define KEY_COL_RIGHT 5
`define KEY_AUX_TWO 6
`define KEY_AUX_THREE 7
`define KEY_COUNT 8

// Columns
`define COL_FIRST 2'h1
`define COL_OUTER 2'h3
`define COL_RESET 2'h1

// Register byte addresses
`define REG_CTRL 8'h00
`define REG_CMD 8'h04
`define REG_STATUS 8'h08
`define REG_PROG 8'h0C

// Control register fields and register reset values
`define CTRL_HEADOPT_LSB 0
`define CTRL_AUX2_LOCK 2
`define CTRL_AUX3_LOCK 3
`define CTRL_DISP_LSB 4
`define CTRL_RESET 6'h00
`define PROG_RESET 8'h00

`endif

/* logic/touchpad_pkg.sv */
// Types for the touchpad controller: state machines and option codes.
// Assumes the constants header is included by the design file.
package touchpad_pkg;

    typedef enum logic [2:0] {
        LIGHT_OFF = 3'b001,
        LIGHT_PARK = 3'b010,
        LIGHT_HEAD = 3'b100
    } light_state_type;

    typedef enum logic [5:0] {
        WIPE_OFF = 6'b000001,
        WIPE_INT = 6'b000010,
        WIPE_LOW = 6'b000100,
        WIPE_HIGH = 6'b001000,
        WIPE_WASH = 6'b010000,
        WIPE_BRIEF = 6'b100000
    } wiper_state_type;

    typedef enum logic [1:0] {
        HEAD_MANUAL = 2'b00,
        HEAD_WITH_WIPERS = 2'b01,
        HEAD_WITH_IGNITION = 2'b10
    } head_option_type;

    typedef enum logic [1:0] {
        DISP_BATTERY = 2'b00,
        DISP_REVISION = 2'b01,
        DISP_PROG = 2'b10
    } display_mode_type;

endpackage : touchpad_pkg

/* logic/touchpad_ctrl.sv */
// Touchpad controller: key debounce, column selection, lights, wipers,
// washer, backlight, auxiliary latches, status window and register port.
// Assumes key, ignition, drive, wake and battery inputs come from pins and
// are asynchronous; the register port runs on SYS_CLK.
`include "touchpad_params.svh"

module touchpad_ctrl
    import touchpad_pkg::*;
#(
    parameter int SEC_CYCLES = `CLK_HZ,
    parameter int DEBOUNCE_CYCLES = `CLK_HZ / 1000 * `DEBOUNCE_MS,
    parameter logic [7:0] SW_REVISION = 8'h5A  // Arbitrary value
) (
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic [`KEY_COUNT-1:0] KEYS,
    input wire logic IGNITION,
    input wire logic TRANS_DRIVE,
    input wire logic WAKE,
    input wire logic [7:0] BATTERY_VOLTS,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    output logic [1:0] ACTIVE_COLUMN,
    output logic PARK_LIGHTS,
    output logic HEAD_LIGHTS,
    output logic HIGH_BEAM,
    output logic WIPER_LOW,
    output logic WIPER_HIGH,
    output logic WASHER,
    output logic BACKLIGHT,
    output logic AUX_TWO,
    output logic AUX_THREE,
    output logic [5:0] WILD_PULSE,
    output logic [7:0] STATUS_VALUE
);

    localparam int SEC_W = $clog2(SEC_CYCLES + 1);
    localparam int DB_W = $clog2(DEBOUNCE_CYCLES + 1);
    localparam logic [SEC_W-1:0] SEC_LAST = SEC_W'(SEC_CYCLES - 1);
    localparam logic [DB_W-1:0] DB_LAST = DB_W'(DEBOUNCE_CYCLES - 1);

    logic [SEC_W-1:0] sec_cnt_q;
    logic sec_tick;
    logic [`KEY_COUNT-1:0] key_press, key_hold, key_long_rel;
    logic [`KEY_COUNT-1:0] cmd_press_q, press;
    logic [1:0] ign_sync_q, drive_sync_q, wake_sync_q;
    logic [7:0] batt_meta_q, batt_q;
    logic ign_prev_q, wake_prev_q, ign_rise, ign_fall, wake_rise;
    logic [5:0] ctrl_q;
    logic [7:0] prog_q;
    logic [1:0] col_q;
    logic [2:0] shift_cnt_q;
    logic shift_fire;
    light_state_type light_q;
    logic beam_q;
    wiper_state_type wiper_q;
    logic [2:0] wtmr_q;
    logic wipe_on_q, washing_q;
    logic [6:0] bl_tmr_q;
    logic aux_two_q, aux_three_q;
    logic col1, wiper_start;
    head_option_type head_opt;
    logic [1:0] col_m1;

    // Shared seconds time base for holds and the shift, wiper and backlight timers
    always_ff @(posedge SYS_CLK) begin
        if (!NRST || sec_tick) begin
            sec_cnt_q <= '0;
        end else begin
            sec_cnt_q <= sec_cnt_q + SEC_W'(1);
        end
    end
    assign sec_tick = (sec_cnt_q == SEC_LAST);

    // Per-key synchroniser, debounce and press/hold classification
    generate
        for (genvar i = 0; i < `KEY_COUNT; i++) begin : g_key
            logic [1:0] sync_q;
            logic stable_q, press_q, hold_q, long_q, commit;
            logic [DB_W-1:0] db_q;
            logic [1:0] held_q;
            assign commit = (sync_q[1] != stable_q) && (db_q == DB_LAST);
            always_ff @(posedge SYS_CLK) begin
                if (!NRST) begin
                    sync_q <= 2'h0;
                    stable_q <= 1'b0;
                    db_q <= '0;
                    held_q <= 2'h0;
                    press_q <= 1'b0;
                    hold_q <= 1'b0;
                    long_q <= 1'b0;
                end else begin
                    sync_q <= {sync_q[0], KEYS[i]};
                    // A change must persist a full debounce period to count
                    if (sync_q[1] == stable_q || commit) begin
                        db_q <= '0;
                    end else begin
                        db_q <= db_q + DB_W'(1);
                    end
                    if (commit) begin
                        stable_q <= sync_q[1];
                    end
                    if (!stable_q) begin
                        held_q <= 2'h0;
                    end else if (sec_tick && held_q < 2'(`WASH_HOLD_SEC)) begin
                        held_q <= held_q + 2'h1;
                    end
                    press_q <= commit && stable_q && (held_q < 2'(`WASH_HOLD_SEC));  // [R20]
                    long_q <= commit && stable_q && (held_q >= 2'(`WASH_HOLD_SEC));  // [R20]
                    hold_q <= stable_q && !commit && sec_tick
                              && (held_q == 2'(`WASH_HOLD_SEC - 1));  // [R20]
                end
            end
            assign key_press[i] = press_q;
            assign key_hold[i] = hold_q;
            assign key_long_rel[i] = long_q;
        end
    endgenerate

    // Level inputs from pins: two flip-flops before use
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            ign_sync_q <= 2'h0;
            drive_sync_q <= 2'h0;
            wake_sync_q <= 2'h0;
            batt_meta_q <= 8'h00;
            batt_q <= 8'h00;
            ign_prev_q <= 1'b0;
            wake_prev_q <= 1'b0;
        end else begin
            ign_sync_q <= {ign_sync_q[0], IGNITION};
            drive_sync_q <= {drive_sync_q[0], TRANS_DRIVE};
            wake_sync_q <= {wake_sync_q[0], WAKE};
            batt_meta_q <= BATTERY_VOLTS;
            batt_q <= batt_meta_q;
            ign_prev_q <= ign_sync_q[1];
            wake_prev_q <= wake_sync_q[1];
        end
    end
    assign ign_rise = ign_sync_q[1] && !ign_prev_q;
    assign ign_fall = !ign_sync_q[1] && ign_prev_q;
    assign wake_rise = wake_sync_q[1] && !wake_prev_q;

    // Keys and port commands feed the same event path
    assign press = key_press | cmd_press_q;  // [R19]
    assign col1 = (col_q == `COL_FIRST);
    assign col_m1 = col_q - 2'h1;
    assign head_opt = head_option_type'(ctrl_q[`CTRL_HEADOPT_LSB +: 2]);

    // Register writes; a command word lives for one cycle only
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            ctrl_q <= `CTRL_RESET;
            prog_q <= `PROG_RESET;
            cmd_press_q <= '0;
        end else begin
            cmd_press_q <= (WR && ADDR == `REG_CMD) ? WDATA[`KEY_COUNT-1:0] : '0;  // [R19]
            if (WR && ADDR == `REG_CTRL) begin
                ctrl_q <= WDATA[5:0];
            end
            if (WR && ADDR == `REG_PROG) begin
                prog_q <= WDATA[7:0];
            end
        end
    end

    // Read data stands only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge SYS_CLK) begin
        if (!NRST || !RD) begin
            RDATA <= 32'h0000_0000;
        end else begin
            case (ADDR)
                `REG_CTRL: RDATA <= {26'h000_0000, ctrl_q};
                `REG_STATUS: RDATA <= {16'h0000, 2'h0, col_q, light_q, beam_q,
                                       wiper_q, washing_q, BACKLIGHT};
                `REG_PROG: RDATA <= {24'h00_0000, prog_q};
                default: RDATA <= 32'h0000_0000;
            endcase
        end
    end

    // Seconds in DRIVE with ignition on, for the automatic column shift
    always_ff @(posedge SYS_CLK) begin
        if (!NRST || !(ign_sync_q[1] && drive_sync_q[1])) begin
            shift_cnt_q <= 3'h0;
        end else if (sec_tick && shift_cnt_q < 3'(`AUTO_SHIFT_SEC)) begin
            shift_cnt_q <= shift_cnt_q + 3'h1;  // [R1]
        end
    end
    assign shift_fire = ign_sync_q[1] && drive_sync_q[1] && sec_tick
                        && (shift_cnt_q == 3'(`AUTO_SHIFT_SEC - 1));

    // Active column: manual keys anytime, automatic shift once per drive entry
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            col_q <= `COL_RESET;
        end else if (shift_fire) begin
            col_q <= `COL_OUTER;  // [R1]
        end else if (press[`KEY_COL_RIGHT] && col_q != `COL_OUTER) begin
            col_q <= col_q + 2'h1;  // [R2]
        end else if (press[`KEY_COL_LEFT] && col_q != `COL_FIRST) begin
            col_q <= col_q - 2'h1;  // [R2]
        end
    end

    // Wipers leaving off, used by the headlight option
    assign wiper_start = (wiper_q == WIPE_OFF) && col1
                         && (press[`KEY_WIPER] || key_hold[`KEY_WIPER]);

    // Lights cycle; automatic paths only ever turn headlights on
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            light_q <= LIGHT_OFF;  // [R21]
        end else if (col1 && press[`KEY_LIGHTS]) begin
            case (light_q)  // [R3]
                LIGHT_OFF: light_q <= LIGHT_PARK;  // [R7]
                LIGHT_PARK: light_q <= LIGHT_HEAD;  // [R7]
                LIGHT_HEAD: light_q <= LIGHT_OFF;  // [R7] [R14]
                default: light_q <= LIGHT_OFF;
            endcase
        end else if ((head_opt == HEAD_WITH_WIPERS && wiper_start)
                     || (head_opt == HEAD_WITH_IGNITION && ign_rise)) begin
            light_q <= LIGHT_HEAD;  // [R13]
        end
    end

    // Beam memory survives lights and ignition off; only the key flips it
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            beam_q <= 1'b0;
        end else if (col1 && light_q == LIGHT_HEAD && press[`KEY_WILD_LEFT]) begin
            beam_q <= !beam_q;  // [R8] [R9]
        end
    end

    // Wild-card remap: one pulse line per column and side, beam key excluded
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            WILD_PULSE <= 6'h00;
        end else begin
            WILD_PULSE <= (6'(press[`KEY_WILD_LEFT] && !col1) << {col_m1, 1'b0})
                          | (6'(press[`KEY_WILD_RIGHT]) << {col_m1, 1'b1});  // [R4]
        end
    end

    // Wiper sequence, wash hold and brief post-wash wipe
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            wiper_q <= WIPE_OFF;  // [R21]
            washing_q <= 1'b0;
        end else if (col1 && key_hold[`KEY_WIPER]) begin
            washing_q <= 1'b1;  // [R17]
            if (wiper_q == WIPE_OFF || wiper_q == WIPE_BRIEF) begin
                wiper_q <= WIPE_WASH;  // [R18]
            end
        end else if (washing_q && key_long_rel[`KEY_WIPER]) begin
            washing_q <= 1'b0;
            if (wiper_q == WIPE_WASH) begin
                wiper_q <= WIPE_BRIEF;  // [R18]
            end
        end else if (col1 && press[`KEY_WIPER]) begin
            case (wiper_q)  // [R15]
                WIPE_OFF: wiper_q <= WIPE_INT;
                WIPE_INT: wiper_q <= WIPE_LOW;
                WIPE_LOW: wiper_q <= WIPE_HIGH;
                WIPE_HIGH: wiper_q <= WIPE_OFF;
                default: wiper_q <= WIPE_INT;
            endcase
        end else if (wiper_q == WIPE_BRIEF && sec_tick
                     && wtmr_q == 3'(`WASH_BRIEF_SEC - 1)) begin
            wiper_q <= WIPE_OFF;  // [R18]
        end
    end

    // Intermittent timing: one wipe second, then a fixed pause
    always_ff @(posedge SYS_CLK) begin
        if (!NRST || !(wiper_q == WIPE_INT || wiper_q == WIPE_BRIEF)) begin
            wtmr_q <= 3'h0;  // [R21]
            wipe_on_q <= 1'b1;
        end else if (wiper_q == WIPE_BRIEF && sec_tick) begin
            wtmr_q <= wtmr_q + 3'h1;
            wipe_on_q <= 1'b1;
        end else if (sec_tick) begin
            if (wipe_on_q && wtmr_q == 3'(`WIPE_SEC - 1)) begin
                wtmr_q <= 3'h0;
                wipe_on_q <= 1'b0;
            end else if (!wipe_on_q && wtmr_q == 3'(`INT_PAUSE_SEC - 1)) begin
                wtmr_q <= 3'h0;  // [R16]
                wipe_on_q <= 1'b1;
            end else begin
                wtmr_q <= wtmr_q + 3'h1;
            end
        end
    end

    // Backlight timer: wake or ignition off reloads, counts down in seconds
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            bl_tmr_q <= 7'h00;  // [R21]
        end else if (wake_rise || ign_fall) begin
            bl_tmr_q <= 7'(`BACKLIGHT_SEC);  // [R11] [R12]
        end else if (sec_tick && bl_tmr_q != 7'h00) begin
            bl_tmr_q <= bl_tmr_q - 7'h01;
        end
    end

    // Always-active aux latches, optionally locked out with ignition on
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            aux_two_q <= 1'b0;
            aux_three_q <= 1'b0;
        end else begin
            if (press[`KEY_AUX_TWO] && !(ign_sync_q[1] && ctrl_q[`CTRL_AUX2_LOCK])) begin
                aux_two_q <= !aux_two_q;  // [R5]
            end
            if (press[`KEY_AUX_THREE] && !(ign_sync_q[1] && ctrl_q[`CTRL_AUX3_LOCK])) begin
                aux_three_q <= !aux_three_q;  // [R5]
            end
        end
    end

    // Registered outputs; one cycle behind the state they mirror
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            ACTIVE_COLUMN <= `COL_RESET;
            PARK_LIGHTS <= 1'b0;
            HEAD_LIGHTS <= 1'b0;
            HIGH_BEAM <= 1'b0;
            WIPER_LOW <= 1'b0;
            WIPER_HIGH <= 1'b0;
            WASHER <= 1'b0;
            BACKLIGHT <= 1'b0;
            AUX_TWO <= 1'b0;
            AUX_THREE <= 1'b0;
        end else begin
            ACTIVE_COLUMN <= col_q;
            PARK_LIGHTS <= (light_q != LIGHT_OFF);
            HEAD_LIGHTS <= (light_q == LIGHT_HEAD);
            HIGH_BEAM <= (light_q == LIGHT_HEAD) && beam_q;
            WIPER_LOW <= wiper_q == WIPE_LOW || wiper_q == WIPE_WASH
                         || ((wiper_q == WIPE_INT || wiper_q == WIPE_BRIEF) && wipe_on_q);
            WIPER_HIGH <= (wiper_q == WIPE_HIGH);
            WASHER <= washing_q;  // [R17]
            BACKLIGHT <= (light_q != LIGHT_OFF) || (bl_tmr_q != 7'h00);  // [R10]
            AUX_TWO <= aux_two_q;
            AUX_THREE <= aux_three_q;
        end
    end

    // Status window source; battery voltage is the normal view
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            STATUS_VALUE <= 8'h00;
        end else begin
            case (display_mode_type'(ctrl_q[`CTRL_DISP_LSB +: 2]))  // [R6]
                DISP_REVISION: STATUS_VALUE <= SW_REVISION;
                DISP_PROG: STATUS_VALUE <= prog_q;
                default: STATUS_VALUE <= batt_q;
            endcase
        end
    end

    // Checks on the behaviour above
    property p_auto_shift;
        @(posedge SYS_CLK) disable iff (!NRST)
        (ign_sync_q[1] && drive_sync_q[1] && sec_tick
         && shift_cnt_q == 3'(`AUTO_SHIFT_SEC - 1))
        |=> (col_q == `COL_OUTER) ##1 (ACTIVE_COLUMN == `COL_OUTER);
    endproperty
    a_auto_shift: assert property (p_auto_shift) else $error("no auto shift");  // [R1]

    property p_col_right;
        @(posedge SYS_CLK) disable iff (!NRST)
        (press[`KEY_COL_RIGHT] && col_q == 2'h1 && !shift_fire) |=> (col_q == 2'h2);
    endproperty
    a_col_right: assert property (p_col_right) else $error("column step wrong");  // [R2]

    property p_lights_step;
        @(posedge SYS_CLK) disable iff (!NRST)
        (col1 && press[`KEY_LIGHTS] && light_q == LIGHT_OFF)
        |=> (light_q == LIGHT_PARK) ##1 (PARK_LIGHTS && !HEAD_LIGHTS);
    endproperty
    a_lights_step: assert property (p_lights_step) else $error("lights step wrong");  // [R7]

    property p_beam;
        @(posedge SYS_CLK) disable iff (!NRST)
        (col1 && light_q == LIGHT_HEAD && press[`KEY_WILD_LEFT]) |=> (beam_q != $past(beam_q));
    endproperty
    a_beam: assert property (p_beam) else $error("beam not toggled");  // [R8]

    property p_no_auto_off;
        @(posedge SYS_CLK) disable iff (!NRST)
        (light_q == LIGHT_HEAD && !(col1 && press[`KEY_LIGHTS])) |=> (light_q == LIGHT_HEAD);
    endproperty
    a_no_auto_off: assert property (p_no_auto_off) else $error("headlights auto off");  // [R14]

    property p_backlight_park;
        @(posedge SYS_CLK) disable iff (!NRST)
        (light_q != LIGHT_OFF) |=> BACKLIGHT;
    endproperty
    a_backlight_park: assert property (p_backlight_park) else $error("backlight dark");  // [R10]

    property p_ign_off_timer;
        @(posedge SYS_CLK) disable iff (!NRST)
        ign_fall |=> (bl_tmr_q == 7'(`BACKLIGHT_SEC)) ##1 BACKLIGHT;
    endproperty
    a_ign_off_timer: assert property (p_ign_off_timer) else $error("no 90 s load");  // [R12]

    property p_wiper_step;
        @(posedge SYS_CLK) disable iff (!NRST)
        (col1 && press[`KEY_WIPER] && !key_hold[`KEY_WIPER] && !key_long_rel[`KEY_WIPER]
         && wiper_q == WIPE_HIGH) |=> (wiper_q == WIPE_OFF);
    endproperty
    a_wiper_step: assert property (p_wiper_step) else $error("wiper step wrong");  // [R15]

    property p_wash;
        @(posedge SYS_CLK) disable iff (!NRST)
        (col1 && key_hold[`KEY_WIPER]) |=> washing_q ##1 WASHER;
    endproperty
    a_wash: assert property (p_wash) else $error("washer not started");  // [R17]

    property p_aux_lock;
        @(posedge SYS_CLK) disable iff (!NRST)
        (ign_sync_q[1] && ctrl_q[`CTRL_AUX2_LOCK]) |=> $stable(aux_two_q);
    endproperty
    a_aux_lock: assert property (p_aux_lock) else $error("aux two not locked");  // [R5]

    property p_reset_off;
        @(posedge SYS_CLK)
        !NRST |=> (light_q == LIGHT_OFF && wiper_q == WIPE_OFF && bl_tmr_q == 7'h00);
    endproperty
    a_reset_off: assert property (p_reset_off) else $error("reset state wrong");  // [R21]

endmodule : touchpad_ctrl

/* verification/key_operator.sv */
// Operator model: a person pressing and releasing the lighted touchpad keys.
// Assumes the bench calls its tasks; levels change only after a rising edge.
module key_operator (
    input wire logic clk,
    output logic [7:0] keys
);
    timeunit 1ns;
    timeprecision 1ps;
    initial keys = 8'h00;
    // Press one key and keep it down
    task automatic down(input int idx);
        @(posedge clk) keys[idx] <= 1'b1;
    endtask : down
    // Release it, then give the debounce time to commit the release
    task automatic up(input int idx);
        @(posedge clk) keys[idx] <= 1'b0;
        repeat (16) @(posedge clk);
    endtask : up
endmodule : key_operator

/* verification/tb_touchpad_lights_wiper_control.sv */
// Self-checking bench for the touchpad controller with an operator model.
// Assumes shortened seconds (20 cycles) and debounce (4 cycles).
module tb_touchpad_lights_wiper_control;
    import touchpad_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] REV = 8'h3C; // Arbitrary value
    logic sys_clk = 0, nrst = 0, ign = 0, drv = 0, wake = 0, wr = 0, rd = 0;
    logic [7:0] keys, addr = 8'h00, volts = 8'h88;
    logic [31:0] wdata = 32'h0000_0000, rdata, rv;
    logic [1:0] col;
    logic park, head, high, wlow, whigh, wash, blight, aux2, aux3;
    logic [5:0] wild;
    logic [5:0] wild_seen = 6'h00;
    // Wild-card pulses last one cycle, so keep the last one seen
    always @(posedge sys_clk) if (wild != 6'h00) wild_seen <= wild;
    logic [7:0] stat;
    int mismatches = 0, cmp_count = 0;
    // Half period of 2.5 ns gives 200 MHz
    always #2.5 sys_clk = ~sys_clk;
    key_operator u_op (.clk(sys_clk), .keys(keys));
    touchpad_ctrl #(.SEC_CYCLES(20), .DEBOUNCE_CYCLES(4), .SW_REVISION(REV)) u_dut (
        .SYS_CLK(sys_clk), .NRST(nrst), .KEYS(keys), .IGNITION(ign), .TRANS_DRIVE(drv),
        .WAKE(wake), .BATTERY_VOLTS(volts), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .ACTIVE_COLUMN(col), .PARK_LIGHTS(park), .HEAD_LIGHTS(head),
        .HIGH_BEAM(high), .WIPER_LOW(wlow), .WIPER_HIGH(whigh), .WASHER(wash),
        .BACKLIGHT(blight), .AUX_TWO(aux2), .AUX_THREE(aux3), .WILD_PULSE(wild),
        .STATUS_VALUE(stat));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
        @(posedge sys_clk) wr <= 1'b0;
    endtask : wr_reg
    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk) begin addr <= a; rd <= 1'b1; end
        @(posedge sys_clk) rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task automatic press(input int idx);
        u_op.down(idx);
        repeat (12) @(posedge sys_clk);
        u_op.up(idx);
    endtask : press
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : wait_cyc
    // Reset state, wake backlight, status window and register port
    task automatic t_reset_regs();
        rd_reg(8'h08, rv);
        chk("status", 32'h0000_1204, rv);
        chk("column", 32'h1, col);
        wr_reg(8'h0C, 32'h0000_00A5);
        rd_reg(8'h0C, rv);
        chk("prog", 32'hA5, rv);
        rd_reg(8'h40, rv);
        chk("unmapped", 32'h0, rv);
        chk("window battery", volts, stat);
        wr_reg(8'h00, 32'h0000_0010);
        wait_cyc(2);
        chk("window revision", REV, stat);
        wr_reg(8'h00, 32'h0000_0020);
        wait_cyc(2);
        chk("window prog", 32'hA5, stat);
        wr_reg(8'h00, 32'h0000_0000);
        @(posedge sys_clk) wake <= 1'b1;
        wait_cyc(8);
        chk("wake backlight", 32'h1, blight);
        wait_cyc(1800);
        chk("backlight expired", 32'h0, blight);
    endtask : t_reset_regs
    // Lights cycle with beam toggle and beam memory
    task automatic t_lights();
        press(0);
        chk("park", 32'h1, park);
        chk("park backlight", 32'h1, blight);
        press(0);
        chk("head", 32'h1, head);
        press(2);
        chk("high beam", 32'h1, high);
        press(0);
        chk("all off", 32'h0, {park, head, high});
        rd_reg(8'h08, rv);
        chk("beam memory", 32'h1, rv[8]);
    endtask : t_lights
    // Wiper speed sequence, then a wash hold from off
    task automatic t_wipers();
        logic [5:0] seq [4] = '{6'h02, 6'h04, 6'h08, 6'h01};
        for (int i = 0; i < 4; i++) begin
            press(1);
            rd_reg(8'h08, rv);
            chk("wiper step", seq[i], rv[7:2]);
        end
        u_op.down(1);
        wait_cyc(70);
        chk("washer on", 32'h1, wash);
        u_op.up(1);
        chk("washer off", 32'h0, wash);
        rd_reg(8'h08, rv);
        chk("brief wipe", 32'h20, rv[7:2]);
        wait_cyc(70);
        rd_reg(8'h08, rv);
        chk("back to off", 32'h01, rv[7:2]);
    endtask : t_wipers
    // Right column key saturates; a port command acts like a key
    task automatic t_columns();
        press(5);
        chk("col 2", 32'h2, col);
        press(5);
        press(5);
        chk("col sat 3", 32'h3, col);
        press(3);
        chk("wild col3", 32'h20, wild_seen);
        press(0);
        chk("lights ignored", 32'h0, park);
        wr_reg(8'h04, 32'h0000_0010);
        wait_cyc(4);
        chk("cmd col", 32'h2, col);
        press(4);
        chk("col 1", 32'h1, col);
    endtask : t_columns
    // Headlights on with ignition, auto shift in drive, no auto off
    task automatic t_ignition();
        wr_reg(8'h00, 32'h0000_0002);
        @(posedge sys_clk) begin ign <= 1'b1; drv <= 1'b1; end
        wait_cyc(20);
        chk("auto head", 32'h1, head);
        wait_cyc(110);
        chk("auto shift", 32'h3, col);
        @(posedge sys_clk) begin ign <= 1'b0; drv <= 1'b0; end
        wait_cyc(40);
        chk("head kept", 32'h1, head);
        press(4);
        press(4);
        press(0);
        chk("lights off", 32'h0, park);
        chk("exit backlight", 32'h1, blight);
    endtask : t_ignition
    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        wait_cyc(2);
        t_reset_regs();
        t_lights();
        t_wipers();
        t_columns();
        t_ignition();
        wrap_up();
    end
    // Whole run takes about 2700 cycles
    initial begin
        #200000;
        mismatches++;
        wrap_up();
    end
endmodule : tb_touchpad_lights_wiper_control
